// ---- logic/rcpc_core.sv ----
// rcpc_core: command decode, power control, oscillator keep-alive, valid flag
// assumes ref_clk is the crystal clock and the clock output passes it 1:1
// Overview of operation
// - general setup resets to 8008h; bits enable tx register and rx fifo
// - decode band field and crystal load in half-picofarad steps
// - power control resets to 8208h; rx chain enables whole receiver
// - tx chain powers synthesizer and amplifier and starts transmission
// - individual bits enable synth, oscillator, battery detector, wake timer; dc bit disables clock
// - both chain bits set means receive mode
// - chain bits force their dependent blocks on regardless of individual bits
// - after a status read, oscillator stops only after 192 clock pulses
// - without a prior status read the clock output stops at once
// - pending interrupts keep oscillator on; status read then allows tail and off
// - clearing oscillator enable does not stop it while interrupts pend
// - clock output disabled: no tail, no interrupt enable, enable bit alone
// - frequency resets to A680h; values outside 96..3903 are ignored
// - carrier equals band base plus parameter times band step
// - bit rate resets to C623h; divisor and prescale set the rate
// - receiver setup resets to 9080h; pin role selects interrupt in or flag out
// - two-bit field selects fast, medium, slow or always valid flag
// - slow: rise when all three detectors high, hold until all low
// - medium: high while locked and either detector high
// - fast follows quality detect; always mode holds flag high
// - three-bit field selects baseband bandwidth, two codes reserved
// - two-bit field selects amplifier gain reduction
// - three-bit field selects signal strength threshold
// - bits enter msb first on rising serial clock while selected
// - chip select spans the whole word; deselect reinitialises the shifter
// - pending interrupt drives active-low request output low
`timescale 1ns/100ps
module rcpc_core (
	// clocks and reset
	input  wire logic            ref_clk,
	input  wire logic            sys_rst,
	input  wire logic            sck,
	// serial command pins
	input  wire logic            chip_select_low,
	input  wire logic            sdi,
	// radio detectors and interrupt sources
	input  wire logic            signal_strength_detect,
	input  wire logic            quality_detect,
	input  wire logic            clock_recovery_locked,
	input  wire logic            irq_event,
	// shared interrupt-in / valid-flag-out pin
	input  wire logic            shared_pin_in,
	output logic                 shared_pin_out,
	output logic                 shared_pin_oe,
	// results
	output logic                 irq_out_low,
	output rcpc_pkg::rcpc_power_t  power_out,
	output rcpc_pkg::rcpc_decode_t decode_out
);
	import rcpc_pkg::*;

	typedef enum {OSC_OFF, OSC_ON, OSC_TAIL} rcpc_osc_t;

	logic [15:0]  cmd_word;
	logic         cmd_toggle;
	logic [5:0]   async_in;
	logic [5:0]   sync1_reg;
	logic [5:0]   sync2_reg;
	logic         tog_seen_reg;
	logic         cs_seen_reg;
	logic         pend_reg;
	logic         pend_next;
	logic         ext_prev_reg;
	logic         tog_change;
	logic         commit;
	logic         is_status;
	logic [15:0]  gen_reg;
	logic [15:0]  gen_next;
	logic [15:0]  pwr_reg;
	logic [15:0]  pwr_next;
	logic [15:0]  frq_reg;
	logic [15:0]  frq_next;
	logic [15:0]  brt_reg;
	logic [15:0]  brt_next;
	logic [15:0]  rcv_reg;
	logic [15:0]  rcv_next;
	logic         irq_reg;
	logic         irq_next;
	logic         ext_fall;
	logic         armed_reg;
	logic         armed_next;
	rcpc_osc_t    osc_reg;
	rcpc_osc_t    osc_next;
	logic [7:0]   tail_reg;
	logic [7:0]   tail_next;
	logic         osc_req;
	logic         dc_bit;
	logic         vdi_reg;
	logic         vdi_next;
	logic         ssd_s;
	logic         qd_s;
	logic         crl_s;
	rcpc_power_t  pwr_out_next;
	rcpc_decode_t dec_next;

	rcpc_spi_shift u_shift (
		.sck             (sck),
		.sys_rst         (sys_rst),
		.chip_select_low (chip_select_low),
		.sdi             (sdi),
		.cmd_word        (cmd_word),
		.cmd_toggle      (cmd_toggle)
	);

	// pin and cross-domain levels pass two flops before use
	assign async_in = {shared_pin_in, clock_recovery_locked, quality_detect,
		signal_strength_detect, chip_select_low, cmd_toggle};
	assign ssd_s = sync2_reg[2];
	assign qd_s  = sync2_reg[3];
	assign crl_s = sync2_reg[4];

	// word frame tracking
	assign tog_change = sync2_reg[0] ^ tog_seen_reg;
	always_comb begin
		pend_next = pend_reg;
		if (tog_change) begin
			pend_next = 1'b1;
		end
		if (sync2_reg[1] & ~cs_seen_reg) begin
			pend_next = 1'b0;
		end
	end
	assign commit    = sync2_reg[1] & ~cs_seen_reg & (pend_reg | tog_change);
	assign is_status = commit & ~cmd_word[STAT_BIT];

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			// idle levels: select and shared pin high, toggle low, so reset makes no false edge
			sync1_reg    <= 6'h22;
			sync2_reg    <= 6'h22;
			tog_seen_reg <= 1'b0;
			cs_seen_reg  <= 1'b1;
			pend_reg     <= 1'b0;
			ext_prev_reg <= 1'b1;
		end else begin
			sync1_reg    <= async_in;
			sync2_reg    <= sync1_reg;
			tog_seen_reg <= sync2_reg[0];
			cs_seen_reg  <= sync2_reg[1];
			pend_reg     <= pend_next;
			ext_prev_reg <= sync2_reg[5];
		end
	end

	// settings registers
	always_comb begin
		gen_next = gen_reg;
		pwr_next = pwr_reg;
		frq_next = frq_reg;
		brt_next = brt_reg;
		rcv_next = rcv_reg;
		if (commit) begin
			if (cmd_word[15:8] == GEN_CODE) begin
				gen_next = cmd_word;
			end
			if (cmd_word[15:8] == PWR_CODE) begin
				pwr_next = cmd_word;
			end
			if (cmd_word[15:12] == FRQ_CODE && cmd_word[11:0] >= FREQ_MIN
				&& cmd_word[11:0] <= FREQ_MAX) begin
				frq_next = cmd_word;
			end
			if (cmd_word[15:8] == BRT_CODE) begin
				brt_next = cmd_word;
			end
			if (cmd_word[15:11] == RCV_CODE) begin
				rcv_next = cmd_word;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gen_reg <= GEN_RST;
			pwr_reg <= PWR_RST;
			frq_reg <= FRQ_RST;
			brt_reg <= BRT_RST;
			rcv_reg <= RCV_RST;
		end else begin
			gen_reg <= gen_next;
			pwr_reg <= pwr_next;
			frq_reg <= frq_next;
			brt_reg <= brt_next;
			rcv_reg <= rcv_next;
		end
	end

	// interrupts and oscillator keep-alive
	assign dc_bit   = pwr_reg[PWR_DC];
	assign ext_fall = ~rcv_reg[RCV_P16] & ext_prev_reg & ~sync2_reg[5];
	assign osc_req  = pwr_reg[PWR_RX] | pwr_reg[PWR_TX] | pwr_reg[PWR_XO] | (~dc_bit & irq_reg);

	always_comb begin
		irq_next   = irq_reg;
		armed_next = armed_reg;
		osc_next   = osc_reg;
		tail_next  = tail_reg;
		// a new event in the clearing cycle wins
		if (is_status) begin
			irq_next   = 1'b0;
			armed_next = 1'b1;
		end
		if (irq_event | ext_fall) begin
			irq_next = 1'b1;
		end
		case (osc_reg)
			OSC_OFF: begin
				if (osc_req) begin
					osc_next = OSC_ON;
				end
			end
			OSC_ON: begin
				if (!osc_req) begin
					if (!dc_bit && armed_reg) begin
						osc_next   = OSC_TAIL;
						tail_next  = 8'h00;
						armed_next = is_status;
					end else begin
						osc_next = OSC_OFF;
					end
				end
			end
			OSC_TAIL: begin
				tail_next = tail_reg + 8'h01;
				if (osc_req) begin
					osc_next = OSC_ON;
				end else if (dc_bit || tail_reg == TAIL_PULSES - 8'h01) begin
					osc_next = OSC_OFF;
				end
			end
			default: begin
				osc_next = OSC_ON;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_reg   <= 1'b1;
			armed_reg <= 1'b0;
			osc_reg   <= OSC_ON;
			tail_reg  <= 8'h00;
		end else begin
			irq_reg   <= irq_next;
			armed_reg <= armed_next;
			osc_reg   <= osc_next;
			tail_reg  <= tail_next;
		end
	end
	assign irq_out_low = ~irq_reg;

	// valid data flag
	always_comb begin
		vdi_next = vdi_reg;
		case (rcpc_vdi_mode_t'(rcv_reg[RCV_VDI+1:RCV_VDI]))
			VDI_FAST:   vdi_next = qd_s;
			VDI_MEDIUM: vdi_next = crl_s & (ssd_s | qd_s);
			VDI_SLOW: begin
				if (ssd_s & qd_s & crl_s) begin
					vdi_next = 1'b1;
				end else if (!(ssd_s | qd_s | crl_s)) begin
					vdi_next = 1'b0;
				end
			end
			VDI_ALWAYS: vdi_next = 1'b1;
			default:    vdi_next = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			vdi_reg <= 1'b0;
		end else begin
			vdi_reg <= vdi_next;
		end
	end
	assign shared_pin_out = vdi_reg;
	assign shared_pin_oe  = rcv_reg[RCV_P16];

	// power outputs and decoded settings
	always_comb begin
		pwr_out_next = '0;
		pwr_out_next.rf_front_on = pwr_reg[PWR_RX];
		pwr_out_next.baseband_on = pwr_reg[PWR_RX] | pwr_reg[PWR_BB];
		pwr_out_next.synth_on = pwr_reg[PWR_RX] | pwr_reg[PWR_TX] | pwr_reg[PWR_SYN];
		pwr_out_next.xtal_run = osc_next != OSC_OFF;
		pwr_out_next.low_batt_detect_on = pwr_reg[PWR_LBD];
		pwr_out_next.wake_timer_on      = pwr_reg[PWR_WAKE];
		pwr_out_next.clk_out_on         = ~dc_bit & (osc_next != OSC_OFF);
		pwr_out_next.rx_mode = pwr_reg[PWR_RX];
		pwr_out_next.pa_on     = pwr_reg[PWR_TX] & ~pwr_reg[PWR_RX];
		pwr_out_next.tx_active = pwr_reg[PWR_TX] & ~pwr_reg[PWR_RX];

		dec_next = '0;
		dec_next.tx_reg_on  = gen_reg[GEN_TXREG];
		dec_next.rx_fifo_on = gen_reg[GEN_RXFIFO];
		dec_next.band_code  = gen_reg[GEN_BAND+1:GEN_BAND];
		dec_next.band_valid = rcpc_band_t'(gen_reg[GEN_BAND+1:GEN_BAND]) != BAND_RSVD;
		dec_next.xtal_load_half_pf = XLOAD_BASE + {2'h0, gen_reg[3:0]};
		dec_next.freq_param = frq_reg[11:0];
		case (rcpc_band_t'(gen_reg[GEN_BAND+1:GEN_BAND]))
			BAND_433: dec_next.carrier_step = BASE_433 + {8'h00, frq_reg[11:0]};
			BAND_868: dec_next.carrier_step = BASE_868 + {7'h00, frq_reg[11:0], 1'b0};
			BAND_915: dec_next.carrier_step = BASE_915 + {8'h00, frq_reg[11:0]}
				+ {7'h00, frq_reg[11:0], 1'b0};
			default:  dec_next.carrier_step = 20'h00000;
		endcase
		dec_next.rate_divisor  = brt_reg[6:0];
		dec_next.rate_prescale = brt_reg[BRT_CS];
		dec_next.rate_clk_div  = brt_reg[BRT_CS]
			? {RATE_PRE * ({5'h00, brt_reg[6:0]} + 12'h001), 3'h0}
			: {3'h0, RATE_PRE * ({5'h00, brt_reg[6:0]} + 12'h001)};
		dec_next.pin_role_sel    = rcv_reg[RCV_P16];
		dec_next.valid_flag_mode = rcv_reg[RCV_VDI+1:RCV_VDI];
		case (rcv_reg[RCV_BW+2:RCV_BW])
			3'h1:    dec_next.bandwidth_khz = 9'h190;
			3'h2:    dec_next.bandwidth_khz = 9'h154;
			3'h3:    dec_next.bandwidth_khz = 9'h10E;
			3'h4:    dec_next.bandwidth_khz = 9'h0C8;
			3'h5:    dec_next.bandwidth_khz = 9'h086;
			3'h6:    dec_next.bandwidth_khz = 9'h043;
			default: dec_next.bandwidth_khz = 9'h000;
		endcase
		case (rcv_reg[RCV_GAIN+1:RCV_GAIN])
			2'h1:    dec_next.lna_cut_db = 5'h06;
			2'h2:    dec_next.lna_cut_db = 5'h0E;
			2'h3:    dec_next.lna_cut_db = 5'h14;
			default: dec_next.lna_cut_db = 5'h00;
		endcase
		case (rcv_reg[2:0])
			3'h0:    dec_next.threshold_neg_dbm = 7'h67;
			3'h1:    dec_next.threshold_neg_dbm = 7'h61;
			3'h2:    dec_next.threshold_neg_dbm = 7'h5B;
			3'h3:    dec_next.threshold_neg_dbm = 7'h55;
			3'h4:    dec_next.threshold_neg_dbm = 7'h4F;
			3'h5:    dec_next.threshold_neg_dbm = 7'h49;
			default: dec_next.threshold_neg_dbm = 7'h00;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_out  <= '0;
			decode_out <= '0;
		end else begin
			power_out  <= pwr_out_next;
			decode_out <= dec_next;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_freq_keep;
		commit && cmd_word[15:12] == FRQ_CODE && (cmd_word[11:0] < FREQ_MIN || cmd_word[11:0] > FREQ_MAX)
			|=> ##1 $stable(decode_out.freq_param);
	endproperty
	a_freq_keep: assert property (p_freq_keep) else $error("bad frequency was taken");

	property p_pwr_commit;
		commit && cmd_word[15:8] == PWR_CODE |=> pwr_reg == $past(cmd_word);
	endproperty
	a_pwr_commit: assert property (p_pwr_commit) else $error("power word not committed");

	property p_both_rx;
		pwr_reg[PWR_RX] && pwr_reg[PWR_TX] |=> power_out.rx_mode && !power_out.pa_on;
	endproperty
	a_both_rx: assert property (p_both_rx) else $error("both chains did not give receive");

	property p_tail_start;
		osc_reg == OSC_ON && !osc_req && !dc_bit && armed_reg |=> osc_reg == OSC_TAIL && tail_reg == 8'h00;
	endproperty
	a_tail_start: assert property (p_tail_start) else $error("tail did not start");

	property p_no_read_stop;
		osc_reg == OSC_ON && !osc_req && !armed_reg |=> osc_reg == OSC_OFF && !power_out.clk_out_on;
	endproperty
	a_no_read_stop: assert property (p_no_read_stop) else $error("clock kept without read");

	property p_irq_keeps_osc;
		irq_reg && !dc_bit |=> osc_reg != OSC_OFF;
	endproperty
	a_irq_keeps_osc: assert property (p_irq_keeps_osc) else $error("oscillator off while pending");

	property p_dc_only_xo;
		dc_bit && !pwr_reg[PWR_RX] && !pwr_reg[PWR_TX] |=> (osc_reg != OSC_OFF) == $past(pwr_reg[PWR_XO]);
	endproperty
	a_dc_only_xo: assert property (p_dc_only_xo) else $error("oscillator not under enable bit");

	property p_slow_hold;
		rcv_reg[RCV_VDI+1:RCV_VDI] == 2'h2 && vdi_reg && (ssd_s || qd_s || crl_s) |=> vdi_reg;
	endproperty
	a_slow_hold: assert property (p_slow_hold) else $error("slow flag dropped early");

	property p_status_clear;
		is_status && !irq_event && !ext_fall |=> irq_out_low;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status read left request");
endmodule

// ---- logic/rcpc_pkg.sv ----
// rcpc_pkg: constants and carrier types of the radio command block
// assumes a 16-bit serial command word, msb first
package rcpc_pkg;
	// command reset values
	localparam logic [15:0] GEN_RST = 16'h8008;
	localparam logic [15:0] PWR_RST = 16'h8208;
	localparam logic [15:0] FRQ_RST = 16'hA680;
	localparam logic [15:0] BRT_RST = 16'hC623;
	localparam logic [15:0] RCV_RST = 16'h9080;
	// fixed upper bit patterns
	localparam logic [7:0] GEN_CODE = 8'h80;
	localparam logic [7:0] PWR_CODE = 8'h82;
	localparam logic [3:0] FRQ_CODE = 4'hA;
	localparam logic [7:0] BRT_CODE = 8'hC6;
	localparam logic [4:0] RCV_CODE = 5'h12;
	localparam int         STAT_BIT = 15;
	// field positions
	localparam int GEN_TXREG  = 7;
	localparam int GEN_RXFIFO = 6;
	localparam int GEN_BAND   = 4;
	localparam int PWR_RX     = 7;
	localparam int PWR_BB     = 6;
	localparam int PWR_TX     = 5;
	localparam int PWR_SYN    = 4;
	localparam int PWR_XO     = 3;
	localparam int PWR_LBD    = 2;
	localparam int PWR_WAKE   = 1;
	localparam int PWR_DC     = 0;
	localparam int BRT_CS     = 7;
	localparam int RCV_P16    = 10;
	localparam int RCV_VDI    = 8;
	localparam int RCV_BW     = 5;
	localparam int RCV_GAIN   = 3;
	// limits and scale factors
	localparam logic [4:0]  CMD_BITS    = 5'h10;
	localparam logic [11:0] FREQ_MIN    = 12'h060;
	localparam logic [11:0] FREQ_MAX    = 12'hF3F;
	localparam logic [7:0]  TAIL_PULSES = 8'hC0;
	localparam logic [19:0] BASE_433    = 20'h29FE0;
	localparam logic [19:0] BASE_868    = 20'h53FC0;
	localparam logic [19:0] BASE_915    = 20'h57E40;
	localparam logic [11:0] RATE_PRE    = 12'h01D;
	localparam logic [5:0]  XLOAD_BASE  = 6'h11;

	typedef enum logic [1:0] {VDI_FAST, VDI_MEDIUM, VDI_SLOW, VDI_ALWAYS} rcpc_vdi_mode_t;
	typedef enum logic [1:0] {BAND_RSVD, BAND_433, BAND_868, BAND_915} rcpc_band_t;

	typedef struct packed {
		logic rf_front_on;
		logic baseband_on;
		logic synth_on;
		logic xtal_run;
		logic pa_on;
		logic low_batt_detect_on;
		logic wake_timer_on;
		logic clk_out_on;
		logic rx_mode;
		logic tx_active;
	} rcpc_power_t;

	typedef struct packed {
		logic        tx_reg_on;
		logic        rx_fifo_on;
		logic        band_valid;
		logic [1:0]  band_code;
		logic [5:0]  xtal_load_half_pf;
		logic [11:0] freq_param;
		logic [19:0] carrier_step;
		logic [6:0]  rate_divisor;
		logic        rate_prescale;
		logic [14:0] rate_clk_div;
		logic        pin_role_sel;
		logic [1:0]  valid_flag_mode;
		logic [8:0]  bandwidth_khz;
		logic [4:0]  lna_cut_db;
		logic [6:0]  threshold_neg_dbm;
	} rcpc_decode_t;
endpackage

// ---- logic/rcpc_spi_shift.sv ----
// rcpc_spi_shift: serial command shifter on the host's serial clock
// assumes sck only toggles while chip_select_low is low
`timescale 1ns/100ps
module rcpc_spi_shift (
	// link clock and resets
	input  wire logic        sck,
	input  wire logic        sys_rst,
	// serial pins
	input  wire logic        chip_select_low,
	input  wire logic        sdi,
	// captured command
	output logic [15:0]      cmd_word,
	output logic             cmd_toggle
);
	import rcpc_pkg::*;

	logic        frame_rst;
	logic [4:0]  cnt_reg;
	logic [4:0]  cnt_next;
	logic [15:0] shift_reg;
	logic [15:0] shift_next;
	logic [15:0] word_next;
	logic        tog_next;

	assign frame_rst = sys_rst | chip_select_low;

	always_comb begin
		cnt_next   = cnt_reg;
		shift_next = {shift_reg[14:0], sdi};
		word_next  = cmd_word;
		tog_next   = cmd_toggle;
		if (cnt_reg != CMD_BITS) begin
			cnt_next = cnt_reg + 5'h01;
		end
		// bits past the sixteenth are ignored
		if (cnt_reg == CMD_BITS - 5'h01) begin
			word_next = shift_next;
			tog_next  = ~cmd_toggle;
		end
	end

	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			cnt_reg   <= 5'h00;
			shift_reg <= 16'h0000;
		end else begin
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
		end
	end

	// held until the next full word, so it is stable when the toggle crosses
	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_word   <= 16'h0000;
			cmd_toggle <= 1'b0;
		end else begin
			cmd_word   <= word_next;
			cmd_toggle <= tog_next;
		end
	end
endmodule

// ---- bench/rcpc_host_model.sv ----
// rcpc_host_model: microcontroller side of the serial command link
// assumes the bench calls send() and nothing else drives these pins
`timescale 1ns/100ps
module rcpc_host_model (
	// serial pins
	output logic sck,
	output logic chip_select_low,
	output logic sdi
);
	localparam real HALF = 80.0;

	initial begin
		sck             = 1'b0;
		chip_select_low = 1'b1;
		sdi             = 1'b1;
	end

	// sck stands still outside frames; nbits below 16 is a deliberate short frame
	task automatic send(input logic [15:0] word, input int nbits);
		int i;
		#(1.3);
		// select held low across the frame
		chip_select_low = 1'b0;
		#(HALF);
		// msb first, data set up half a period before each rise
		for (i = 0; i < nbits; i++) begin
			sdi = word[15 - i];
			#(HALF);
			sck = 1'b1;
			#(HALF);
			sck = 1'b0;
		end
		#(HALF);
		chip_select_low = 1'b1;
		// a released line must not keep showing a valid bit
		sdi = ~sdi;
		#(HALF);
	endtask
endmodule

// ---- bench/tb_radio_config_power_control.sv ----
// tb_radio_config_power_control: self-checking bench of the command block
// assumes rcpc_core as top and the host model driving the serial pins
`timescale 1ns/100ps
module tb_radio_config_power_control;
	import rcpc_pkg::*;
	logic         ref_clk, sys_rst, sck, chip_select_low, sdi;
	logic         ssd, qd, crl, irq_event, shared_pin_in;
	logic         shared_pin_out, shared_pin_oe, irq_out_low;
	rcpc_power_t  pw;
	rcpc_decode_t dc;
	int           err_count, comparisons, i;
	int           bw[8]   = '{0, 400, 340, 270, 200, 134, 67, 0};
	int           gn[4]   = '{0, 6, 14, 20};
	int           th[8]   = '{103, 97, 91, 85, 79, 73, 0, 0};
	int           base[4] = '{0, 172000, 344000, 360000};

	rcpc_core i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sck(sck), .chip_select_low(chip_select_low),
		.sdi(sdi), .signal_strength_detect(ssd), .quality_detect(qd), .clock_recovery_locked(crl),
		.irq_event(irq_event), .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
		.shared_pin_oe(shared_pin_oe), .irq_out_low(irq_out_low), .power_out(pw), .decode_out(dc));
	rcpc_host_model i_host (.sck(sck), .chip_select_low(chip_select_low), .sdi(sdi));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// full frame, then room for the commit and the registered outputs
	task automatic cmd(input logic [15:0] word);
		tick(1);
		i_host.send(word, 16);
		tick(12);
	endtask

	task automatic det(input logic s, input logic q, input logic l, input logic exp);
		ssd = s;
		qd  = q;
		crl = l;
		tick(6);
		check("valid_data_flag", shared_pin_out, exp);
	endtask

	task automatic pulse_irq();
		irq_event = 1'b1;
		tick(1);
		irq_event = 1'b0;
		tick(4);
	endtask

	task automatic end_sim();
		if (err_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#300000;
		err_count++;
		end_sim();
	end

	initial begin
		{sys_rst, ssd, qd, crl, irq_event, shared_pin_in} = 6'b100001;
		err_count = 0;
		comparisons = 0;
		tick(8);
		sys_rst = 1'b0;
		tick(3);
		check("irq_out_low", irq_out_low, 1'b0);
		check("osc_clk", {pw.xtal_run, pw.clk_out_on, pw.rx_mode, pw.pa_on}, 4'hC);
		check("general", {dc.tx_reg_on, dc.rx_fifo_on, dc.band_code, dc.xtal_load_half_pf}, 10'h019);
		check("freq", dc.freq_param, 12'h680);
		check("rate", dc.rate_clk_div, 15'h414);
		check("pin_role", {dc.pin_role_sel, shared_pin_oe, dc.bandwidth_khz}, 11'h0C8);
		// frequency range limits, both sides of each bound
		cmd(16'hA060);
		check("freq", dc.freq_param, 12'h060);
		cmd(16'hA05F);
		check("freq", dc.freq_param, 12'h060);
		cmd(16'hAF3F);
		check("freq", dc.freq_param, 12'hF3F);
		cmd(16'hAF40);
		check("freq", dc.freq_param, 12'hF3F);
		tick(1);
		i_host.send(16'hA100, 12);
		tick(12);
		check("short_frame", dc.freq_param, 12'hF3F);
		for (i = 0; i < 4; i++) begin
			cmd({8'h80, 2'b11, i[1:0], 4'hF});
			check("general", {dc.tx_reg_on, dc.rx_fifo_on, dc.band_code, dc.xtal_load_half_pf},
				{2'b11, i[1:0], 6'h20});
			check("band_valid", dc.band_valid, i != 0);
			check("carrier", dc.carrier_step, (i == 0) ? 0 : base[i] + i * 3903);
		end
		cmd(16'hC6FF);
		check("rate", {dc.rate_prescale, dc.rate_divisor, dc.rate_clk_div}, {8'hFF, 15'h7400});
		check("freq_kept", dc.freq_param, 12'hF3F);
		for (i = 0; i < 8; i++) begin
			cmd({5'b10010, 3'b111, i[2:0], i[1:0], i[2:0]});
			check("bandwidth", dc.bandwidth_khz, bw[i]);
			check("lna", dc.lna_cut_db, gn[i % 4]);
			check("threshold", dc.threshold_neg_dbm, th[i]);
		end
		check("flag_out", {shared_pin_oe, shared_pin_out}, 2'b11);
		cmd(16'h9400);
		det(1'b0, 1'b1, 1'b0, 1'b1);
		det(1'b1, 1'b0, 1'b1, 1'b0);
		cmd(16'h9500);
		det(1'b1, 1'b0, 1'b1, 1'b1);
		det(1'b0, 1'b1, 1'b1, 1'b1);
		det(1'b1, 1'b1, 1'b0, 1'b0);
		cmd(16'h9600);
		check("vdi_mode", dc.valid_flag_mode, 2'h2);
		det(1'b1, 1'b1, 1'b0, 1'b0);
		det(1'b1, 1'b1, 1'b1, 1'b1);
		det(1'b1, 1'b0, 1'b0, 1'b1);
		det(1'b0, 1'b0, 1'b0, 1'b0);
		// status read clears the power-on interrupt and arms the tail
		cmd(16'h0000);
		check("irq_out_low", irq_out_low, 1'b1);
		cmd(16'h8280);
		check("rx_chain", {pw.rf_front_on, pw.baseband_on, pw.synth_on, pw.xtal_run, pw.pa_on}, 5'h1E);
		cmd(16'h8220);
		check("tx_chain", {pw.pa_on, pw.synth_on, pw.xtal_run, pw.tx_active, pw.rf_front_on}, 5'h1E);
		cmd(16'h82A0);
		check("rx_mode", {pw.rx_mode, pw.pa_on}, 2'b10);
		check("rx_wins", pw.tx_active, 1'b0);
		cmd(16'h825E);
		check("baseband", {pw.baseband_on, pw.rx_mode, pw.pa_on}, 3'h4);
		check("singles", {pw.synth_on, pw.xtal_run, pw.low_batt_detect_on, pw.wake_timer_on,
			pw.clk_out_on, pw.rf_front_on}, 6'h3E);
		cmd(16'h8200);
		tick(140);
		check("tail_run", {pw.xtal_run, pw.clk_out_on}, 2'b11);
		tick(60);
		check("tail_end", {pw.xtal_run, pw.clk_out_on}, 2'b00);
		cmd(16'h8208);
		cmd(16'h8200);
		check("no_tail", pw.xtal_run, 1'b0);
		pulse_irq();
		check("irq_wake", {irq_out_low, pw.xtal_run}, 2'b01);
		cmd(16'h8200);
		check("irq_hold", pw.xtal_run, 1'b1);
		cmd(16'h0000);
		check("irq_clear", {irq_out_low, pw.xtal_run}, 2'b11);
		tick(200);
		check("irq_off", pw.xtal_run, 1'b0);
		cmd(16'h8201);
		pulse_irq();
		check("dc_set", {irq_out_low, pw.xtal_run, pw.clk_out_on}, 3'b000);
		cmd(16'h0000);
		cmd(16'h9080);
		check("pin_in", shared_pin_oe, 1'b0);
		shared_pin_in = 1'b0;
		tick(6);
		check("ext_irq", irq_out_low, 1'b0);
		end_sim();
	end
endmodule
